//--- rtl/sadc_ctrl.sv
// Added by the designer: the AXI4-Lite slave port and the register addresses.
module sadc_ctrl
   import sadc_pkg::*;
(
   input  wire logic                   CLK_SYS_IN,
   input  wire logic                   RST_IN,
   input  wire logic                   SAMPLE_STROBE_IN,
   input  wire logic                   SERIAL_CLOCK_IN,
   input  wire logic                   COMPARE_IN,
   output logic                        TRACK_HOLD_OUT,
   output logic                        COARSE_CHARGE_OUT,
   output logic                        RANGE_BIPOLAR_OUT,
   output logic [SADC_RES_BITS-1:0]    DAC_TRIAL_OUT,
   output logic                        MUX_SELECT_OUT,
   output logic                        CHANNEL_OUT,
   output logic                        CHANNEL_OE_OUT,
   output logic                        SERIAL_CLOCK_OUT,
   output logic                        SERIAL_CLOCK_OE_OUT,
   output logic                        SERIAL_RESULT_OUT,
   input  wire logic [SADC_ADDR_W-1:0] S_AXI_AWADDR_IN,
   input  wire logic                   S_AXI_AWVALID_IN,
   output logic                        S_AXI_AWREADY_OUT,
   input  wire logic [31:0]            S_AXI_WDATA_IN,
   input  wire logic [3:0]             S_AXI_WSTRB_IN,
   input  wire logic                   S_AXI_WVALID_IN,
   output logic                        S_AXI_WREADY_OUT,
   output logic [1:0]                  S_AXI_BRESP_OUT,
   output logic                        S_AXI_BVALID_OUT,
   input  wire logic                   S_AXI_BREADY_IN,
   input  wire logic [SADC_ADDR_W-1:0] S_AXI_ARADDR_IN,
   input  wire logic                   S_AXI_ARVALID_IN,
   output logic                        S_AXI_ARREADY_OUT,
   output logic [31:0]                 S_AXI_RDATA_OUT,
   output logic [1:0]                  S_AXI_RRESP_OUT,
   output logic                        S_AXI_RVALID_OUT,
   input  wire logic                   S_AXI_RREADY_IN
);
   sadc_state_e                state;
   logic [SADC_CTRL_W-1:0]     ctrl;
   logic [6:0]                 conv_cnt;
   logic [6:0]                 free_cnt;
   logic [2:0]                 coarse_cnt;
   logic [2:0]                 strobe_sync;
   logic [2:0]                 sclk_sync;
   logic [SADC_RES_BITS-1:0]   dac;
   logic [SADC_RES_BITS-1:0]   pending;
   logic [SADC_RES_BITS-1:0]   result;
   logic [SADC_RES_BITS-1:0]   shifter;
   logic [4:0]                 shift_cnt;
   logic                       ser_out;
   logic                       sclk_int;
   logic                       free_chan;
   logic                       aw_got;
   logic                       w_got;
   logic [SADC_ADDR_W-1:0]     awaddr_r;
   logic [31:0]                wdata_r;
   logic [3:0]                 wstrb_r;
   logic                       bvalid;
   logic [1:0]                 bresp;
   logic                       rvalid;
   logic [1:0]                 rresp;
   logic [31:0]                rdata;
   logic                       ext_clk;
   logic                       pipelined;
   logic                       free_mode;
   logic                       twos;
   logic                       converting;
   logic                       strobe_fall;
   logic                       sclk_fall;
   logic                       start;
   logic                       conv_end;
   logic [3:0]                 bit_idx;
   logic [SADC_RES_BITS-1:0]   next_coded;
   logic                       aw_hs;
   logic                       w_hs;
   logic                       do_wr;
   logic [SADC_ADDR_W-1:0]     wr_addr;
   logic [31:0]                wr_data;
   logic [3:0]                 wr_strb;

   // Mode decode from the two select bits
   assign ext_clk    = ctrl[SADC_BIT_SCKDIR];
   assign pipelined  = ctrl[SADC_BIT_SCKDIR] & ctrl[SADC_BIT_OUTTIME];
   assign free_mode  = ~ctrl[SADC_BIT_SCKDIR] & ~ctrl[SADC_BIT_OUTTIME];
   assign twos       = ctrl[SADC_BIT_TWOS];
   assign converting = (state == SADC_CONV);
   assign conv_end   = converting && (conv_cnt == SADC_CONV_LAST);
   assign bit_idx    = ~conv_cnt[5:2];
   // Pin synchronisers, third stage only for edge finding
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         strobe_sync <= 3'h7;
         sclk_sync   <= 3'h7;
      end else begin
         strobe_sync <= {strobe_sync[1:0], SAMPLE_STROBE_IN};
         sclk_sync   <= {sclk_sync[1:0], SERIAL_CLOCK_IN};
      end
   end
   assign strobe_fall = strobe_sync[2] & ~strobe_sync[1];
   assign sclk_fall   = sclk_sync[2] & ~sclk_sync[1];
   // Start source: timer in free-run, strobe fall otherwise
   assign start = free_mode ? (free_cnt == 7'h00)
                            : (strobe_fall && !converting);
   // Free-run period timer
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN || !free_mode) begin
         free_cnt <= 7'h01;
      end else if (free_cnt == SADC_FREE_LAST) begin
         free_cnt <= 7'h00;
      end else begin
         free_cnt <= free_cnt + 7'h01;
      end
   end
   // Track and convert sequencing
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         state      <= SADC_COARSE;
         conv_cnt   <= 7'h00;
         coarse_cnt <= 3'h0;
      end else begin
         unique case (state)
            SADC_COARSE, SADC_FINE: begin
               if (start) begin
                  state    <= SADC_CONV;
                  conv_cnt <= 7'h00;
               end else if (state == SADC_COARSE) begin
                  if (coarse_cnt == SADC_COARSE_LAST) begin
                     state <= SADC_FINE;
                  end
                  coarse_cnt <= coarse_cnt + 3'h1;
               end
            end
            SADC_CONV: begin
               conv_cnt <= conv_cnt + 7'h01;
               if (conv_end) begin
                  state      <= SADC_COARSE;
                  coarse_cnt <= 3'h0;
               end
            end
            default: begin
               state <= SADC_COARSE;
            end
         endcase
      end
   end
   // Successive approximation and internal shift clock
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         dac      <= 16'h0000;
         sclk_int <= 1'b1;
      end else if (start && !converting) begin
         dac      <= 16'h8000;
         sclk_int <= 1'b1;
      end else if (converting && !conv_cnt[6]) begin
         if (conv_cnt[1:0] == 2'h1) begin
            dac[bit_idx] <= COMPARE_IN;
            sclk_int     <= 1'b0;
         end else if (conv_cnt[1:0] == 2'h3) begin
            sclk_int <= 1'b1;
            if (bit_idx != 4'h0) begin
               dac[bit_idx - 4'h1] <= 1'b1;
            end
         end
      end
   end
   // Output coding applied to the finished code
   assign next_coded = {dac[15] ^ twos, dac[14:0]};
   // Result holding for register read and pipelined transfer
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         pending <= 16'h0000;
         result  <= 16'h0000;
      end else if (conv_end) begin
         pending <= next_coded;
         result  <= next_coded;
      end
   end
   // Serial port shifter and data pin
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         shifter   <= 16'hffff;
         shift_cnt <= SADC_SHIFT_DONE;
         ser_out   <= 1'b1;
      end else if (!ext_clk) begin
         shift_cnt <= SADC_SHIFT_DONE;
         if (converting && !conv_cnt[6] && conv_cnt[1:0] == 2'h1) begin
            ser_out <= COMPARE_IN ^ (twos && bit_idx == 4'hf);
         end
      end else if (start && pipelined) begin
         shifter   <= pending;
         ser_out   <= pending[15];
         shift_cnt <= 5'h00;
      end else if (start) begin
         shifter   <= 16'hffff;
         ser_out   <= 1'b1;
         shift_cnt <= SADC_SHIFT_DONE;
      end else if (conv_end && !pipelined) begin
         shifter   <= next_coded;
         ser_out   <= next_coded[15];
         shift_cnt <= 5'h00;
      end else if (sclk_fall) begin
         shifter <= {shifter[14:0], 1'b1};
         ser_out <= shifter[14];
         if (shift_cnt != SADC_SHIFT_DONE) begin
            shift_cnt <= shift_cnt + 5'h01;
         end
      end
   end
   // Free-run channel alternation
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         free_chan <= 1'b0;
      end else if (free_mode && start) begin
         free_chan <= ~free_chan;
      end
   end
   // Analog side controls
   assign TRACK_HOLD_OUT      = converting;
   assign COARSE_CHARGE_OUT   = (state == SADC_COARSE)
                                || (!converting && ctrl[SADC_BIT_FORCE]);
   assign RANGE_BIPOLAR_OUT   = ctrl[SADC_BIT_BIPOLAR];
   assign DAC_TRIAL_OUT       = dac;
   assign MUX_SELECT_OUT      = free_mode ? free_chan : ctrl[SADC_BIT_CHANSEL];
   assign CHANNEL_OUT         = free_chan;
   assign CHANNEL_OE_OUT      = free_mode;
   assign SERIAL_CLOCK_OUT    = sclk_int;
   assign SERIAL_CLOCK_OE_OUT = !ext_clk;
   assign SERIAL_RESULT_OUT   = ser_out;

   // Bus write channel, address and data in either order
   assign S_AXI_AWREADY_OUT = !aw_got && !bvalid;
   assign S_AXI_WREADY_OUT  = !w_got && !bvalid;
   assign aw_hs   = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
   assign w_hs    = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
   assign do_wr   = (aw_got || aw_hs) && (w_got || w_hs);
   assign wr_addr = aw_got ? awaddr_r : S_AXI_AWADDR_IN;
   assign wr_data = w_got ? wdata_r : S_AXI_WDATA_IN;
   assign wr_strb = w_got ? wstrb_r : S_AXI_WSTRB_IN;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         aw_got   <= 1'b0;
         w_got    <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= SADC_RESP_OKAY;
      end else if (do_wr) begin
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         bvalid <= 1'b1;
         bresp  <= (wr_addr[1:0] == 2'h0 && wr_addr <= SADC_OFS_RESULT)
                   ? SADC_RESP_OKAY : SADC_RESP_SLVERR;
      end else begin
         if (aw_hs) begin
            aw_got   <= 1'b1;
            awaddr_r <= S_AXI_AWADDR_IN;
         end
         if (w_hs) begin
            w_got   <= 1'b1;
            wdata_r <= S_AXI_WDATA_IN;
            wstrb_r <= S_AXI_WSTRB_IN;
         end
         if (bvalid && S_AXI_BREADY_IN) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Control register, low byte lane only
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         ctrl <= SADC_CTRL_RESET;
      end else if (do_wr && wr_addr == SADC_OFS_CTRL && wr_strb[0]) begin
         ctrl <= wr_data[SADC_CTRL_W-1:0];
      end
   end

   assign S_AXI_BVALID_OUT = bvalid;
   assign S_AXI_BRESP_OUT  = bresp;

   // Bus read channel
   assign S_AXI_ARREADY_OUT = !rvalid;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         rvalid <= 1'b0;
         rresp  <= SADC_RESP_OKAY;
         rdata  <= 32'h00000000;
      end else if (S_AXI_ARVALID_IN && !rvalid) begin
         rvalid <= 1'b1;
         rresp  <= SADC_RESP_OKAY;
         unique case (S_AXI_ARADDR_IN)
            SADC_OFS_CTRL:   rdata <= {26'h0, ctrl};
            SADC_OFS_STATUS: rdata <= {22'h0, shift_cnt, free_chan, COARSE_CHARGE_OUT, 1'b0, state};
            SADC_OFS_RESULT: rdata <= {16'h0, result};
            default: begin
               rdata <= 32'h00000000;
               rresp <= SADC_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && S_AXI_RREADY_IN) begin
         rvalid <= 1'b0;
      end
   end

   assign S_AXI_RVALID_OUT = rvalid;
   assign S_AXI_RDATA_OUT  = rdata;
   assign S_AXI_RRESP_OUT  = rresp;

   // Checks on the design's own behaviour
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);

   conv_length_a: assert property ($rose(converting) |-> ##65 converting ##1 !converting)
      else $error("conversion did not last 66 cycles");
   free_period_a: assert property ((start && free_mode) |-> ##80 (start || !free_mode))
      else $error("free-run start not 80 cycles apart");
   strobe_ignored_a: assert property ((free_mode && strobe_fall && free_cnt != 7'h00) |-> !start)
      else $error("strobe started a conversion in free-run");
   mux_follow_a: assert property (!free_mode |-> MUX_SELECT_OUT == ctrl[SADC_BIT_CHANSEL])
      else $error("multiplexer not steered by channel select");
   coarse_six_a: assert property ($fell(converting) |-> COARSE_CHARGE_OUT[*6])
      else $error("coarse charge shorter than six cycles");
   fine_after_a: assert property (($fell(converting) ##5 (!start && !ctrl[SADC_BIT_FORCE])) |=> !COARSE_CHARGE_OUT)
      else $error("no fine charge after six coarse cycles");
   force_coarse_a: assert property ((ctrl[SADC_BIT_FORCE] && !converting) |-> COARSE_CHARGE_OUT)
      else $error("force did not engage coarse charge");
   start_edge_a: assert property ((strobe_fall && !free_mode && !converting) |=> converting)
      else $error("strobe fall did not start conversion");
   coding_a: assert property (conv_end |=> result == {$past(dac[15]) ^ $past(twos), $past(dac[14:0])})
      else $error("result coding wrong");
   ones_after_a: assert property ((ext_clk && shift_cnt == SADC_SHIFT_DONE && sclk_fall && !start
                                   && !conv_end) |=> SERIAL_RESULT_OUT)
      else $error("ones not shifted after sixteenth edge");
   pipe_load_a: assert property ((pipelined && start) |=> shift_cnt == 5'h00 && shifter == $past(pending)
                                 && SERIAL_RESULT_OUT == $past(pending[15]))
      else $error("pipelined result not released at strobe");
   sclk_low_a: assert property ((!ext_clk && $fell(SERIAL_CLOCK_OUT)) |-> ##2 SERIAL_CLOCK_OUT)
      else $error("internal shift clock low phase wrong");
   chan_toggle_a: assert property ((free_mode && start) |=> CHANNEL_OUT != $past(CHANNEL_OUT))
      else $error("free-run channel did not alternate");

endmodule

//--- rtl/sadc_pkg.sv
package sadc_pkg;
   // Conversion timing in master clock cycles
   localparam int unsigned SADC_RES_BITS      = 16;
   localparam int unsigned SADC_CONV_CYCLES   = 66;
   localparam int unsigned SADC_FREE_PERIOD   = 80;
   localparam int unsigned SADC_COARSE_CYCLES = 6;
   localparam int unsigned SADC_SCLK_DIV      = 4;
   localparam logic [6:0]  SADC_CONV_LAST     = 7'(SADC_CONV_CYCLES - 1);
   localparam logic [6:0]  SADC_FREE_LAST     = 7'(SADC_FREE_PERIOD - 1);
   localparam logic [2:0]  SADC_COARSE_LAST   = 3'(SADC_COARSE_CYCLES - 1);
   localparam logic [4:0]  SADC_SHIFT_DONE    = 5'(SADC_RES_BITS);

   // Register map, byte addresses
   localparam int unsigned SADC_ADDR_W     = 4;
   localparam logic [3:0]  SADC_OFS_CTRL   = 4'h0;
   localparam logic [3:0]  SADC_OFS_STATUS = 4'h4;
   localparam logic [3:0]  SADC_OFS_RESULT = 4'h8;

   // Control register fields
   localparam int unsigned SADC_CTRL_W       = 6;
   localparam int unsigned SADC_BIT_SCKDIR   = 0;
   localparam int unsigned SADC_BIT_OUTTIME  = 1;
   localparam int unsigned SADC_BIT_BIPOLAR  = 2;
   localparam int unsigned SADC_BIT_TWOS     = 3;
   localparam int unsigned SADC_BIT_CHANSEL  = 4;
   localparam int unsigned SADC_BIT_FORCE    = 5;
   localparam logic [5:0]  SADC_CTRL_RESET   = 6'h03;

   // Bus responses
   localparam logic [1:0]  SADC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  SADC_RESP_SLVERR = 2'h2;

   // Track and convert phases, gray along coarse, fine, convert
   typedef enum logic [1:0] {
      SADC_COARSE = 2'h0,
      SADC_FINE   = 2'h1,
      SADC_CONV   = 2'h3
   } sadc_state_e;
endpackage

//--- tb/sadc_far_end.sv
module sadc_far_end
   import sadc_pkg::*;
(
   input  wire logic [SADC_RES_BITS-1:0] dac_trial_in,
   input  wire logic                     mux_select_in,
   input  wire logic [SADC_RES_BITS-1:0] level0_in,
   input  wire logic [SADC_RES_BITS-1:0] level1_in,
   input  wire logic                     serial_data_in,
   output logic                          compare_out,
   output logic                          shift_clock_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [17:0] rx_word;

   // Comparator on the selected analogue level
   assign compare_out = ((mux_select_in ? level1_in : level0_in) >= dac_trial_in);

   // Shift clock stands high outside frames
   initial begin
      shift_clock_out = 1'b1;
      rx_word = '1;
   end

   // Host clocks n bits at 800 ns, taking each bit just before the fall
   task automatic shift(input int n);
      rx_word = '1;
      repeat (n) begin
         rx_word = {rx_word[16:0], serial_data_in};
         #10 shift_clock_out = 1'b0;
         #400 shift_clock_out = 1'b1;
         #390;
      end
   endtask
endmodule

//--- tb/tb_sadc_ctrl.sv
module tb_sadc_ctrl
   import sadc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        strobe  = 1'b1;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [3:0]  awaddr  = 4'h0;
   logic [3:0]  araddr  = 4'h0;
   logic [3:0]  wstrb   = 4'hf;
   logic [31:0] wdata   = 32'h0;
   logic [15:0] level0  = 16'h0;
   logic [15:0] level1  = 16'h0;
   logic        track_hold, coarse, range_bip, mux_sel, chan, chan_oe, sclk_o, sclk_oe, sdat, compare, sclk_far;
   logic        awready, wready, bvalid, arready, rvalid, sclk_pin;
   logic [1:0]  bresp, rresp, rsp;
   logic [15:0] dac, sc_word;
   logic [31:0] rdata, rd;
   logic        c0;
   int          n_errors = 0;
   int          compares = 0;
   int          lat, hold, crs, sc_fall, sc_low, t1;
   logic [15:0] lv [4] = '{16'h8000, 16'hffff, 16'h0000, 16'h1234};
   logic        tw [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic [15:0] ex [4] = '{16'h0000, 16'h7fff, 16'h8000, 16'h1234};

   // Master clock, 100 ns
   always #50 clk_sys = ~clk_sys;

   // Shift clock pin: device drives it when enabled
   assign sclk_pin = sclk_oe ? sclk_o : sclk_far;

   sadc_ctrl dut_u (
      .CLK_SYS_IN(clk_sys), .RST_IN(rst), .SAMPLE_STROBE_IN(strobe), .SERIAL_CLOCK_IN(sclk_pin),
      .COMPARE_IN(compare), .TRACK_HOLD_OUT(track_hold), .COARSE_CHARGE_OUT(coarse), .RANGE_BIPOLAR_OUT(range_bip),
      .DAC_TRIAL_OUT(dac), .MUX_SELECT_OUT(mux_sel), .CHANNEL_OUT(chan), .CHANNEL_OE_OUT(chan_oe),
      .SERIAL_CLOCK_OUT(sclk_o), .SERIAL_CLOCK_OE_OUT(sclk_oe), .SERIAL_RESULT_OUT(sdat),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));

   sadc_far_end far_u (
      .dac_trial_in(dac), .mux_select_in(mux_sel), .level0_in(level0), .level1_in(level1),
      .serial_data_in(sdat), .compare_out(compare), .shift_clock_out(sclk_far));

   // Reporting and comparison
   task automatic fail(input string s);
      n_errors++;
      $display("CHECK FAILED t=%0t %s", $time, s);
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
   endtask

   task automatic check_ser(input logic [17:0] got, input logic [17:0] exp, input string what);
      compares++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Bus write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_hit;
      logic w_hit;
      logic b_hit;
      int   n;
      b_hit = 1'b0;
      n = 0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_hit && n < 100) begin
         @(negedge clk_sys);
         aw_hit = awvalid & awready;
         w_hit = wvalid & wready;
         b_hit = bvalid;
         if (bvalid) rsp = bresp;
         @(posedge clk_sys);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         if (b_hit) bready <= 1'b0;
         n++;
      end
      if (!b_hit) fail("write timeout");
      #1;
   endtask

   // Bus read: data and response sampled on the falling edge before the handshake edge
   task automatic axi_rd(input logic [3:0] a);
      logic ar_hit;
      logic r_hit;
      int   n;
      r_hit = 1'b0;
      n = 0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_hit && n < 100) begin
         @(negedge clk_sys);
         ar_hit = arvalid & arready;
         r_hit = rvalid;
         rd = rdata;
         rsp = rresp;
         @(posedge clk_sys);
         if (ar_hit) arvalid <= 1'b0;
         if (r_hit) rready <= 1'b0;
         n++;
      end
      if (!r_hit) fail("read timeout");
      #1;
   endtask

   // One conversion: strobe falls at count 'at' (never if negative), then hold and coarse are timed
   task automatic run_conv(input int at);
      logic p;
      lat = 0;
      hold = 0;
      crs = 0;
      sc_fall = 0;
      sc_low = 0;
      sc_word = 16'h0;
      while (!track_hold && lat < 200) begin
         @(posedge clk_sys);
         if (lat == at) strobe <= 1'b0;
         if (lat == at + 3) strobe <= 1'b1;
         #1;
         lat++;
      end
      p = sclk_o;
      while (track_hold && hold < 200) begin
         @(posedge clk_sys);
         strobe <= 1'b1;
         #1;
         hold++;
         if (p && !sclk_o) sc_fall++;
         if (!p && sclk_o) sc_word = {sc_word[14:0], sdat};
         if (!sclk_o) sc_low++;
         p = sclk_o;
      end
      while (coarse && crs < 200) begin
         @(posedge clk_sys);
         #1;
         crs++;
      end
   endtask

   // Timing of a strobe-started conversion
   task automatic check_conv();
      check_word({31'h0, (lat >= 23 && lat <= 25)}, 32'h1, "start latency");
      check_word(32'(hold), 32'd66, "hold length");
      check_word(32'(crs), 32'd6, "coarse length");
      check_word({31'h0, coarse}, 32'h0, "fine after coarse");
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      axi_rd(SADC_OFS_CTRL);
      check_word(rd, 32'h3, "ctrl reset");
      repeat (10) @(posedge clk_sys);
      axi_rd(SADC_OFS_STATUS);
      check_word({28'h0, rd[3:0]}, 32'h1, "status fine");
      axi_rd(4'hc);
      check_word({30'h0, rsp}, {30'h0, SADC_RESP_SLVERR}, "unmapped");
      axi_wr(4'hc, 32'h0);
      check_word({30'h0, rsp}, {30'h0, SADC_RESP_SLVERR}, "unmapped write");
      wstrb <= 4'h0;
      axi_wr(SADC_OFS_CTRL, 32'h3c);
      wstrb <= 4'hf;
      axi_rd(SADC_OFS_CTRL);
      check_word(rd, 32'h3, "strobe off write");
      for (int m = 0; m < 8; m++) begin
         axi_wr(SADC_OFS_CTRL, 32'(m));
         axi_rd(SADC_OFS_CTRL);
         check_word(rd, 32'(m), "ctrl rw");
         check_word({29'h0, sclk_oe, chan_oe, range_bip}, {29'h0, !m[0], m[1:0] == 2'b00, m[2]}, "pins");
      end
      for (int i = 0; i < 4; i++) begin
         level0 <= lv[i];
         axi_wr(SADC_OFS_CTRL, {28'h0, tw[i], 3'b001});
         run_conv(20);
         check_conv();
         axi_rd(SADC_OFS_RESULT);
         check_word(rd, {16'h0, ex[i]}, "result");
         far_u.shift(18);
         check_ser(far_u.rx_word, {ex[i], 2'b11}, "burst");
      end
      axi_wr(SADC_OFS_CTRL, 32'h21);
      check_word({31'h0, coarse}, 32'h1, "force on");
      axi_wr(SADC_OFS_CTRL, 32'h01);
      check_word({31'h0, coarse}, 32'h0, "force off");
      axi_wr(SADC_OFS_CTRL, 32'h21);
      check_word({31'h0, coarse}, 32'h1, "force again");
      level1 <= 16'h4321;
      axi_wr(SADC_OFS_CTRL, 32'h11);
      check_word({31'h0, mux_sel}, 32'h1, "mux");
      run_conv(20);
      check_conv();
      axi_rd(SADC_OFS_RESULT);
      check_word(rd, 32'h4321, "channel two");
      axi_wr(SADC_OFS_CTRL, 32'h03);
      level0 <= 16'h00ff;
      run_conv(20);
      level0 <= 16'h5a5a;
      run_conv(20);
      far_u.shift(18);
      check_ser(far_u.rx_word, {16'h00ff, 2'b11}, "pipelined");
      level0 <= 16'hc3a5;
      run_conv(20);
      far_u.shift(4);
      check_ser(far_u.rx_word, {14'h3fff, 4'h5}, "partial");
      run_conv(20);
      far_u.shift(18);
      check_ser(far_u.rx_word, {16'hc3a5, 2'b11}, "discard");
      level0 <= 16'ha5c3;
      axi_wr(SADC_OFS_CTRL, 32'h02);
      run_conv(20);
      check_word({16'h0, sc_word}, 32'ha5c3, "self clocked");
      check_word(32'(sc_fall), 32'd16, "clock pulses");
      check_word(32'(sc_low), 32'd32, "clock low time");
      axi_wr(SADC_OFS_CTRL, 32'h00);
      run_conv(-1);
      t1 = hold + crs;
      c0 = chan;
      run_conv(2);
      check_word(32'(t1 + lat), 32'd80, "free period");
      check_word({31'h0, chan}, {31'h0, ~c0}, "free channel");
      print_verdict();
   end

   // Watchdog well beyond the expected run
   initial begin
      #1ms;
      fail("timeout");
      print_verdict();
   end
endmodule
